/* File: hw/dbr_debug_data_reg.sv */
/*
  debug data/count register, its compare mask, and the register
  breakpoint data match with a one-cycle break request.
  assumes the debug command port, engine strobes and instruction
  destination bus are synchronous to clk; tap_tlr is high while the
  TAP sits in Test-Logic-Reset.
*/
`timescale 1ns/1ns
module dbr_debug_data_reg #(
  parameter int DATA_W = dbr_pkg::DATA_W,
  parameter int ADDR_W = dbr_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tap_tlr,
  input wire logic jtag_cmd_valid,
  input wire logic jtag_cmd_write,
  input wire dbr_pkg::dbr_sel_e jtag_cmd_sel,
  input wire logic [DATA_W-1:0] jtag_cmd_wdata,
  output logic [DATA_W-1:0] jtag_rdata,
  output logic jtag_ack,
  input wire logic eng_load,
  input wire logic [DATA_W-1:0] eng_load_data,
  input wire logic eng_count_dec,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  output logic [DATA_W-1:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic bp_armed,
  input wire logic [ADDR_W-1:0] bp_addr,
  input wire logic instr_valid,
  input wire logic [ADDR_W-1:0] dst_addr,
  input wire logic [DATA_W-1:0] dst_data,
  output logic break_req,
  output logic [DATA_W-1:0] data_value,
  output logic [DATA_W-1:0] mask_value,
  output logic count_zero
);

  // refuse widths the reset constants cannot cover
  if (DATA_W < 1 || DATA_W > 16) begin : g_chk_data
    $error("DATA_W must be 1 to 16");
  end
  if (ADDR_W < 1) begin : g_chk_addr
    $error("ADDR_W must be at least 1");
  end

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] jtag_rdata;
    logic jtag_ack;
    logic [DATA_W-1:0] cpu_rdata;
    logic cpu_rvalid;
    logic brk;
    logic cnt_zero;
  } dbr_state_s;

  dbr_state_s q;
  dbr_state_s next_q;
  logic addr_hit;
  logic data_match;
  logic [DATA_W-1:0] data_rst;
  logic [DATA_W-1:0] mask_rst;

  assign data_rst = dbr_pkg::DATA_RESET[DATA_W-1:0];
  assign mask_rst = dbr_pkg::MASK_RESET[DATA_W-1:0];

  // destination address matches the armed breakpoint
  assign addr_hit = bp_armed & instr_valid &
                    (dst_addr == bp_addr);

  // masked compare of new destination data against stored pattern
  dbr_mask_cmp #(
    .W(DATA_W)
  ) u_cmp (
    .ref_data(q.data),
    .mask(q.mask),
    .new_data(dst_data),
    .match(data_match)
  );

  // next state: debug command first, then engine load, then count
  always_comb begin
    next_q = q;
    next_q.jtag_ack = 1'b0;
    next_q.cpu_rvalid = 1'b0;
    if (jtag_cmd_valid) begin
      next_q.jtag_ack = 1'b1;
      if (jtag_cmd_write) begin
        if (jtag_cmd_sel == dbr_pkg::DBR_SEL_MASK) begin
          next_q.mask = jtag_cmd_wdata;
        end else begin
          next_q.data = jtag_cmd_wdata;
        end
      end else begin
        if (jtag_cmd_sel == dbr_pkg::DBR_SEL_MASK) begin
          next_q.jtag_rdata = q.mask;
        end else begin
          next_q.jtag_rdata = q.data;
        end
      end
    end else if (eng_load) begin
      next_q.data = eng_load_data;
    end else if (eng_count_dec && (q.data != '0)) begin
      next_q.data = DATA_W'(q.data - 1'b1);
    end
    // cpu only reads; cpu_wr has no path into the state
    if (cpu_rd) begin
      next_q.cpu_rvalid = 1'b1;
      next_q.cpu_rdata = q.data;
    end
    // one pulse per matching instruction
    next_q.brk = addr_hit & data_match;
    next_q.cnt_zero = (next_q.data == '0);
    if (rst || tap_tlr) begin
      next_q.data = data_rst;
      next_q.mask = mask_rst;
      next_q.jtag_rdata = '0;
      next_q.jtag_ack = 1'b0;
      next_q.cpu_rdata = '0;
      next_q.cpu_rvalid = 1'b0;
      next_q.brk = 1'b0;
      next_q.cnt_zero = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= next_q;
  end

  // outputs straight from the state flops
  assign jtag_rdata = q.jtag_rdata;
  assign jtag_ack = q.jtag_ack;
  assign cpu_rdata = q.cpu_rdata;
  assign cpu_rvalid = q.cpu_rvalid;
  assign break_req = q.brk;
  assign data_value = q.data;
  assign mask_value = q.mask;
  assign count_zero = q.cnt_zero;

  // checks on the register and breakpoint behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_por_clears: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> (data_value == data_rst) && (mask_value == mask_rst))
    else $error("reset did not restore data and mask");

  a_tlr_clears_data: assert property (
    tap_tlr |=> (data_value == data_rst) && !break_req && !jtag_ack)
    else $error("test-logic-reset did not clear data");

  a_tlr_sets_mask: assert property (
    tap_tlr |=> mask_value == mask_rst)
    else $error("mask not all ones in test-logic-reset");

  a_cpu_wr_ignored: assert property (
    cpu_wr && !jtag_cmd_valid && !eng_load && !eng_count_dec && !tap_tlr
    |=> $stable(data_value) && $stable(mask_value))
    else $error("cpu write altered the register");

  a_cpu_read_value: assert property (
    cpu_rd && !tap_tlr |=> cpu_rvalid && (cpu_rdata == $past(data_value)))
    else $error("cpu read returned wrong value");

  a_jtag_wr_data: assert property (
    jtag_cmd_valid && jtag_cmd_write && !tap_tlr &&
    (jtag_cmd_sel == dbr_pkg::DBR_SEL_DATA)
    |=> jtag_ack && (data_value == $past(jtag_cmd_wdata)))
    else $error("debug write to data register lost");

  a_jtag_rd_mask: assert property (
    jtag_cmd_valid && !jtag_cmd_write && !tap_tlr &&
    (jtag_cmd_sel == dbr_pkg::DBR_SEL_MASK)
    |=> jtag_ack && (jtag_rdata == $past(mask_value)) && $stable(mask_value))
    else $error("debug read of mask wrong");

  a_no_cmd_no_ack: assert property (
    !jtag_cmd_valid |=> !jtag_ack)
    else $error("ack without a debug command");

  a_count_down: assert property (
    eng_count_dec && !eng_load && !jtag_cmd_valid && !tap_tlr &&
    (data_value != '0)
    |=> data_value == DATA_W'($past(data_value) - 1'b1))
    else $error("read count did not step down by one");

  a_count_flag: assert property (
    count_zero == (data_value == '0))
    else $error("count_zero disagrees with data");

  a_break_on_match: assert property (
    addr_hit && !tap_tlr && (((dst_data ^ data_value) & mask_value) == '0)
    |=> break_req)
    else $error("masked match gave no break");

  a_no_break_miss: assert property (
    addr_hit && !tap_tlr &&
    (((dst_data ^ data_value) & mask_value) != '0) |=> !break_req)
    else $error("break on unmasked mismatch");

  a_zero_mask_any: assert property (
    addr_hit && !tap_tlr && (mask_value == '0) |=> break_req)
    else $error("zero mask did not break on address match");

  a_break_cause: assert property (
    break_req |-> $past(addr_hit))
    else $error("break without destination address match");

  c_break: cover property (addr_hit ##1 break_req);
  c_jtag_write: cover property (jtag_cmd_valid && jtag_cmd_write ##1 jtag_ack);
  c_count_zero: cover property (eng_count_dec && !count_zero ##1 count_zero);
  c_tlr: cover property (tap_tlr ##1 !tap_tlr);

endmodule : dbr_debug_data_reg

/* File: hw/dbr_mask_cmp.sv */
/*
  masked equality check between the stored pattern and new data.
  assumes the mask and both data words share one width.
*/
`timescale 1ns/1ns
module dbr_mask_cmp #(
  parameter int W = 16
) (
  input wire logic [W-1:0] ref_data,
  input wire logic [W-1:0] mask,
  input wire logic [W-1:0] new_data,
  output logic match
);

  // refuse a width the compare cannot serve
  if (W < 1) begin : g_chk_w
    $error("W must be at least 1");
  end

  logic [W-1:0] bit_ok;

  // per bit: equal where mask is one, don't-care where zero
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign bit_ok[i] = ~mask[i] |
                       (ref_data[i] == new_data[i]);
  end

  // all-zero mask gives all ones here, so any data matches
  assign match = &bit_ok;

endmodule : dbr_mask_cmp

/* File: hw/dbr_pkg.sv */
/*
  constants, reset values and command selects for the debug data and
  breakpoint register block.
  assumes a single 125 MHz clock and a synchronous active-high reset.
*/
// Overview of operation
// - data register goes to 0000h on power-on reset or Test-Logic-Reset.
// - cpu may read the data register any time; cpu writes change nothing.
// - a valid JTAG debug command may read or write the data or the mask register; the engine also loads the data register.
// - engine uses the 16-bit register as data value or read count.
// - break compares destination data with the register on mask-one bits.
// - bit positions with mask bit zero are ignored in the comparison.
// - all-zero mask breaks on any data once the break address matches.
// - mask register goes to FFFFh on power-on reset or Test-Logic-Reset.
package dbr_pkg;

  // register and address widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // values after reset
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;

  // cycles from request to answer
  localparam int READ_LAT = 1;
  localparam int BREAK_LAT = 1;

  // target of a debug command
  typedef enum logic [0:0] {
    DBR_SEL_DATA = 1'b0,
    DBR_SEL_MASK = 1'b1
  } dbr_sel_e;

endpackage : dbr_pkg

/* File: verif/dbr_debug_data_reg_tb_top.sv */
/*
  self-checking bench for the debug data and breakpoint register.
  assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ns
module dbr_debug_data_reg_tb_top;
  logic clk, rst, tap_tlr, eng_load, eng_count_dec, cpu_rd, cpu_wr;
  logic bp_armed, instr_valid, valid, write, ack, rvalid, brk, cz, a;
  logic [15:0] eng_d, dst_data, wdata, rdata, crd, dval, mval, r;
  logic [7:0] bp_addr, dst_addr;
  dbr_pkg::dbr_sel_e sel;
  int miscompares, checks;

  dbr_host_model host (.clk(clk), .valid(valid), .write(write),
    .sel(sel), .wdata(wdata), .rdata(rdata), .ack(ack));
  dbr_debug_data_reg DUT (.clk(clk), .rst(rst), .tap_tlr(tap_tlr),
    .jtag_cmd_valid(valid), .jtag_cmd_write(write), .jtag_cmd_sel(sel),
    .jtag_cmd_wdata(wdata), .jtag_rdata(rdata), .jtag_ack(ack),
    .eng_load(eng_load), .eng_load_data(eng_d),
    .eng_count_dec(eng_count_dec), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_rdata(crd), .cpu_rvalid(rvalid), .bp_armed(bp_armed),
    .bp_addr(bp_addr), .instr_valid(instr_valid), .dst_addr(dst_addr),
    .dst_data(dst_data), .break_req(brk), .data_value(dval),
    .mask_value(mval), .count_zero(cz));

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // one instruction writing d to address ad, break expected or not
  task hit(input logic [7:0] ad, input logic [15:0] d, input logic e);
    @(posedge clk);
    instr_valid <= 1'b1;
    dst_addr <= ad;
    dst_data <= d;
    @(posedge clk);
    instr_valid <= 1'b0;
    dst_data <= ~d;
    #1 chk("break", brk, e);
    @(posedge clk);
    #1 chk("break end", brk, 0);
  endtask : hit

  task t_jtag;
    host.cmd(1, dbr_pkg::DBR_SEL_DATA, 16'h1234, r, a);
    chk("ack", a, 1);
    chk("data", dval, 16'h1234);
    host.cmd(0, dbr_pkg::DBR_SEL_MASK, 16'h0000, r, a);
    chk("mask rd", r, dbr_pkg::MASK_RESET);
    host.cmd(0, dbr_pkg::DBR_SEL_DATA, 16'h0000, r, a);
    chk("data rd", r, 16'h1234);
  endtask : t_jtag

  task t_cpu;
    @(posedge clk);
    cpu_rd <= 1'b1;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    #1 chk("rvalid", rvalid, 1);
    chk("cpu data", crd, 16'h1234);
    @(posedge clk);
    #1 chk("cpu wr", dval, 16'h1234);
  endtask : t_cpu

  // load a count of 2, decrement three times, last one saturates
  task t_eng;
    @(posedge clk);
    eng_load <= 1'b1;
    eng_d <= 16'h0002;
    @(posedge clk);
    eng_load <= 1'b0;
    eng_count_dec <= 1'b1;
    repeat (3) @(posedge clk);
    eng_count_dec <= 1'b0;
    #1 chk("count", dval, 16'h0000);
    chk("zero", cz, 1);
  endtask : t_eng

  task t_bp;
    host.cmd(1, dbr_pkg::DBR_SEL_DATA, 16'hA5F0, r, a);
    @(posedge clk);
    bp_armed <= 1'b1;
    bp_addr <= 8'h3C;
    hit(8'h3C, 16'hA5F0, 1);
    hit(8'h3C, 16'hA5F1, 0);
    hit(8'h3D, 16'hA5F0, 0);
    host.cmd(1, dbr_pkg::DBR_SEL_MASK, 16'hFF00, r, a);
    hit(8'h3C, 16'hA5FF, 1);
    hit(8'h3C, 16'hA4F0, 0);
    host.cmd(1, dbr_pkg::DBR_SEL_MASK, 16'h0000, r, a);
    hit(8'h3C, 16'h1357, 1);
    @(posedge clk);
    bp_armed <= 1'b0;
    hit(8'h3C, 16'h1357, 0);
  endtask : t_bp

  // test-logic-reset clears data and sets the mask
  task t_tlr;
    @(posedge clk);
    tap_tlr <= 1'b1;
    @(posedge clk);
    tap_tlr <= 1'b0;
    #1 chk("tlr data", dval, dbr_pkg::DATA_RESET);
    chk("tlr mask", mval, dbr_pkg::MASK_RESET);
    chk("tlr rdata", rdata, 16'h0000);
    chk("tlr cpu rdata", crd, 16'h0000);
  endtask : t_tlr

  // mid-run reset clears the data register; first command after it works
  task t_rst;
    host.cmd(1, dbr_pkg::DBR_SEL_DATA, 16'h5A3C, r, a);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk("rst2 data", dval, dbr_pkg::DATA_RESET);
    chk("rst2 zero", cz, 1);
    host.cmd(0, dbr_pkg::DBR_SEL_DATA, 16'h0000, r, a);
    chk("rst2 ack", a, 1);
    chk("rst2 rd", r, dbr_pkg::DATA_RESET);
  endtask : t_rst

  // watchdog, far beyond the roughly 60 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    {rst, tap_tlr, eng_load, eng_count_dec, cpu_rd, cpu_wr} = 6'h3F;
    {tap_tlr, eng_load, eng_count_dec, cpu_rd, cpu_wr} = 5'h00;
    {bp_armed, instr_valid} = 2'h0;
    {bp_addr, dst_addr, eng_d, dst_data} = 48'h0;
    miscompares = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk("rst data", dval, dbr_pkg::DATA_RESET);
    chk("rst mask", mval, dbr_pkg::MASK_RESET);
    chk("rst zero", cz, 1);
    t_jtag();
    t_cpu();
    t_eng();
    t_bp();
    t_tlr();
    t_rst();
    conclude();
  end
endmodule : dbr_debug_data_reg_tb_top

/* File: verif/dbr_host_model.sv */
/*
  behavioural debug host that issues commands on the debug port.
  assumes commands are taken on a rising edge and acked one cycle later.
*/
`timescale 1ns/1ns
module dbr_host_model (
  input wire logic clk,
  output logic valid,
  output logic write,
  output dbr_pkg::dbr_sel_e sel,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  // idle port, no command pending
  initial begin
    valid = 1'b0;
    write = 1'b0;
    sel = dbr_pkg::DBR_SEL_DATA;
    wdata = 16'h0000;
  end

  // one command, held for one edge; mask register written only this way
  task cmd(input logic w, input dbr_pkg::dbr_sel_e s,
           input logic [15:0] d, output logic [15:0] r,
           output logic a);
    @(posedge clk);
    valid <= 1'b1;
    write <= w;
    sel <= s;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    wdata <= ~d; // released data is not left showing the old value
    #1;
    r = rdata;
    a = ack;
  endtask : cmd
endmodule : dbr_host_model
